// ==== src/gpiod_pkg.sv ====
// package: register map, field positions and reset values of the port block
`default_nettype none
package gpiod_pkg;
    localparam int NPORT = 5;
    localparam int AW = 12;
    // word indexes of the registers (all printed offsets are word indexes; byte address is four times the index)
    localparam logic [7:0] IDX_PORT0_DATA = 8'hd0;
    localparam logic [7:0] IDX_PORT1_DATA = 8'hd1;
    localparam logic [7:0] IDX_PORT2_DATA = 8'hd2;
    localparam logic [7:0] IDX_PORT4_DATA = 8'hd4;
    localparam logic [7:0] IDX_PORT5_DATA = 8'hd5;
    localparam logic [7:0] IDX_PORT0_PULLUP = 8'he0;
    localparam logic [7:0] IDX_PORT1_PULLUP = 8'he1;
    localparam logic [7:0] IDX_PORT2_PULLUP = 8'he2;
    localparam logic [7:0] IDX_PORT4_PULLUP = 8'he4;
    localparam logic [7:0] IDX_PORT5_PULLUP = 8'he5;
    localparam logic [7:0] IDX_OD_CTRL = 8'he9;
    localparam logic [7:0] IDX_PORT0_DIR = 8'hb8;
    localparam logic [7:0] IDX_PORT1_DIR = 8'hc1;
    localparam logic [7:0] IDX_PORT2_DIR = 8'hc2;
    localparam logic [7:0] IDX_PORT4_DIR = 8'hc4;
    localparam logic [7:0] IDX_PORT5_DIR = 8'hc5;
    // bit set / bit clear registers, one per data port (set index = data index + 8'h20, clear index = data index + 8'h28)
    localparam logic [7:0] IDX_BIT_SET = 8'hf0;
    localparam logic [7:0] IDX_BIT_CLR = 8'hf8;
    localparam logic [7:0] PORT_RESET = 8'h00;
    localparam logic [7:0] PORT0_MASK = 8'h1f;
    localparam logic [7:0] FULL_MASK = 8'hff;
    localparam int OD_BIT = 2;
    localparam int OD_PORT = 4;
    localparam logic [1:0] ADDR_LSB_ZERO = 2'h0;
endpackage : gpiod_pkg
`default_nettype wire

// ==== src/gpiod_if.sv ====
// interface: decoded register access passed from the bus slave to the port core
`default_nettype none
interface gpiod_if;
    logic wr;
    logic [7:0] idx;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic hit;
    modport bus (output wr, output idx, output wdata, input rdata, input hit);
    modport core (input wr, input idx, input wdata, output rdata, output hit);
endinterface : gpiod_if
`default_nettype wire

// ==== src/gpiod_apb.sv ====
// module: apb slave, single-cycle ready, error on unmapped address
`default_nettype none
module gpiod_apb (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [gpiod_pkg::AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic pslverr,
    output logic [31:0] prdata,
    gpiod_if.bus regs
);
    logic [31:0] prdata_reg, prdata_next;
    logic aligned;
    logic decoded;

    // ==========================================================
    // decode
    assign aligned = paddr[1:0] == gpiod_pkg::ADDR_LSB_ZERO;
    assign regs.idx = paddr[9:2];
    assign regs.wdata = pwdata[7:0];
    // write takes effect only at the access edge with ready high
    assign decoded = aligned && regs.hit && (paddr[gpiod_pkg::AW-1:10] == '0);
    assign regs.wr = psel && penable && pwrite && decoded;
    assign pready = 1'b1; // always answers in the access cycle
    assign pslverr = psel && penable && !decoded;
    assign prdata = prdata_reg;

    // read data captured in setup so it is registered during access
    always_comb begin
        prdata_next = prdata_reg;
        if (psel && !penable) begin
            // refused reads return zero, not a stray register
            prdata_next = decoded ? {24'h000000, regs.rdata} : 32'h00000000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h00000000;
        end else begin
            prdata_reg <= prdata_next;
        end
    end
endmodule : gpiod_apb
`default_nettype wire

// ==== src/gpiod_top.sv ====
// file: port data, direction, pull-up and open-drain logic with apb access
// Notes on behaviour
// RL1 - write-only pull-up enable per pin, 1 connects pull-up, clears at reset
// RL2 - data register read returns pin levels of input pins
// RL3 - byte write loads output latch, output pins drive it, latches reset 0
// RL4 - bit set and clear change only the addressed latch bit
// RL5 - open-drain only on port five bit two, control bit two
// RL6 - software makes that pin an output when enabling open-drain
// RL7 - open-drain pulls low on latch 0, releases on latch 1
// RL8 - open-drain control is write-only, resets 0, byte writes only
// RL9 - disabling open-drain restores the previous direction
// RL10 - software should set the latch high before enabling open-drain
// RL11 - direction bit per pin, read/write, resets 0, 1 means output
// RL12 - unused upper bits of port zero ignore writes and read zero
`default_nettype none
module gpiod_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [gpiod_pkg::AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic pslverr,
    output logic [31:0] prdata,
    input wire logic [39:0] pin_in,
    output logic [39:0] pin_out,
    output logic [39:0] pin_oe,
    output logic [39:0] pullup_en
);
    gpiod_if regs_if ();

    logic [7:0] data_reg [gpiod_pkg::NPORT];
    logic [7:0] data_next [gpiod_pkg::NPORT];
    logic [7:0] dir_reg [gpiod_pkg::NPORT];
    logic [7:0] dir_next [gpiod_pkg::NPORT];
    logic [7:0] pull_reg [gpiod_pkg::NPORT];
    logic [7:0] pull_next [gpiod_pkg::NPORT];
    logic od_reg, od_next;
    logic [39:0] oe_reg, oe_next;
    logic [39:0] out_reg, out_next;
    logic [39:0] pu_reg, pu_next;

    // ==========================================================
    // helpers
    // mask of implemented pins for a port index
    function automatic logic [7:0] port_mask(input int p);
        port_mask = (p == 0) ? gpiod_pkg::PORT0_MASK : gpiod_pkg::FULL_MASK; // see RL12
    endfunction : port_mask

    // map a register index onto a port number, -1 when none
    function automatic int port_of(input logic [7:0] i, input logic [7:0] base);
        port_of = -1;
        case (i - base)
            8'h00: port_of = 0;
            8'h01: port_of = 1;
            8'h02: port_of = 2;
            8'h04: port_of = 3;
            8'h05: port_of = 4;
            default: port_of = -1;
        endcase
    endfunction : port_of

    function automatic int dir_port(input logic [7:0] i);
        dir_port = -1;
        case (i)
            gpiod_pkg::IDX_PORT0_DIR: dir_port = 0;
            gpiod_pkg::IDX_PORT1_DIR: dir_port = 1;
            gpiod_pkg::IDX_PORT2_DIR: dir_port = 2;
            gpiod_pkg::IDX_PORT4_DIR: dir_port = 3;
            gpiod_pkg::IDX_PORT5_DIR: dir_port = 4;
            default: dir_port = -1;
        endcase
    endfunction : dir_port

    // ==========================================================
    // bus slave
    gpiod_apb u_apb (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .pready(pready),
        .pslverr(pslverr),
        .prdata(prdata),
        .regs(regs_if.bus)
    );

    // ==========================================================
    // address hit and read mux
    always_comb begin
        int dp;
        int pp;
        int up;
        int sp;
        int cp;
        dp = port_of(regs_if.idx, gpiod_pkg::IDX_PORT0_DATA);
        pp = dir_port(regs_if.idx);
        up = port_of(regs_if.idx, gpiod_pkg::IDX_PORT0_PULLUP);
        sp = port_of(regs_if.idx, gpiod_pkg::IDX_BIT_SET);
        cp = port_of(regs_if.idx, gpiod_pkg::IDX_BIT_CLR);
        regs_if.hit = (dp >= 0) || (pp >= 0) || (up >= 0) || (sp >= 0) || (cp >= 0)
            || (regs_if.idx == gpiod_pkg::IDX_OD_CTRL);
        regs_if.rdata = 8'h00; // write-only registers read zero, see RL1 see RL8
        if (dp >= 0) begin
            // input pins show the pin, output pins the latch
            for (int b = 0; b < 8; b++) begin
                regs_if.rdata[b] = dir_reg[dp][b] ? data_reg[dp][b]
                    : pin_in[dp*8+b]; // see RL2
            end
            regs_if.rdata = regs_if.rdata & port_mask(dp); // see RL12
        end else if (pp >= 0) begin
            regs_if.rdata = dir_reg[pp]; // see RL11
        end
    end

    // ==========================================================
    // register writes
    always_comb begin
        int dp;
        int pp;
        int up;
        int sp;
        int cp;
        dp = port_of(regs_if.idx, gpiod_pkg::IDX_PORT0_DATA);
        pp = dir_port(regs_if.idx);
        up = port_of(regs_if.idx, gpiod_pkg::IDX_PORT0_PULLUP);
        sp = port_of(regs_if.idx, gpiod_pkg::IDX_BIT_SET);
        cp = port_of(regs_if.idx, gpiod_pkg::IDX_BIT_CLR);
        data_next = data_reg;
        dir_next = dir_reg;
        pull_next = pull_reg;
        od_next = od_reg;
        if (regs_if.wr) begin
            if (dp >= 0) begin
                data_next[dp] = regs_if.wdata & port_mask(dp); // see RL3 see RL12
            end
            if (sp >= 0) begin
                // wdata is a one-hot bit mask; other bits stay put
                data_next[sp] = (data_reg[sp] | regs_if.wdata) & port_mask(sp); // see RL4
            end
            if (cp >= 0) begin
                data_next[cp] = data_reg[cp] & ~regs_if.wdata; // see RL4
            end
            if (pp >= 0) begin
                dir_next[pp] = regs_if.wdata & port_mask(pp); // see RL11
            end
            if (up >= 0) begin
                pull_next[up] = regs_if.wdata & port_mask(up); // see RL1
            end
            if (regs_if.idx == gpiod_pkg::IDX_OD_CTRL) begin
                od_next = regs_if.wdata[gpiod_pkg::OD_BIT]; // see RL5 see RL8
            end
        end
    end

    // ==========================================================
    // pad drive: direction bits are never touched by open-drain, so clearing
    // the control bit falls back to whatever mode the pin held
    always_comb begin
        for (int p = 0; p < gpiod_pkg::NPORT; p++) begin
            for (int b = 0; b < 8; b++) begin
                oe_next[p*8+b] = dir_reg[p][b]; // see RL3
                out_next[p*8+b] = data_reg[p][b];
                pu_next[p*8+b] = pull_reg[p][b]; // see RL1
            end
        end
        if (od_reg) begin
            // relies on software keeping the pin an output, see RL6 see RL10
            oe_next[gpiod_pkg::OD_PORT*8+gpiod_pkg::OD_BIT] =
                dir_reg[gpiod_pkg::OD_PORT][gpiod_pkg::OD_BIT]
                && !data_reg[gpiod_pkg::OD_PORT][gpiod_pkg::OD_BIT]; // see RL7 see RL9
            out_next[gpiod_pkg::OD_PORT*8+gpiod_pkg::OD_BIT] = 1'b0; // see RL7
        end
    end

    assign pin_oe = oe_reg;
    assign pin_out = out_reg;
    assign pullup_en = pu_reg;

    // state registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int p = 0; p < gpiod_pkg::NPORT; p++) begin
                data_reg[p] <= gpiod_pkg::PORT_RESET;
                dir_reg[p] <= gpiod_pkg::PORT_RESET;
                pull_reg[p] <= gpiod_pkg::PORT_RESET;
            end
            od_reg <= 1'b0;
            oe_reg <= '0;
            out_reg <= '0;
            pu_reg <= '0;
        end else begin
            data_reg <= data_next;
            dir_reg <= dir_next;
            pull_reg <= pull_next;
            od_reg <= od_next;
            oe_reg <= oe_next;
            out_reg <= out_next;
            pu_reg <= pu_next;
        end
    end
endmodule : gpiod_top
`default_nettype wire

// ==== testbench/gpiod_board.sv ====
// board model: pad level from device drive, external drivers and pull-ups
`default_nettype none
module gpiod_board (
    input wire logic pclk,
    input wire logic [39:0] pin_out,
    input wire logic [39:0] pin_oe,
    input wire logic [39:0] pullup_en,
    input wire logic [39:0] ext_drv,
    input wire logic [39:0] ext_val,
    output logic [39:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [39:0] wobble = 40'h0;
    // a floating pad wanders, so no test may lean on its last level
    always @(posedge pclk) wobble <= ~wobble;
    // =========== pad resolution
    always_comb begin
        for (int i = 0; i < 40; i++) begin
            if (pin_oe[i]) pin_in[i] = pin_out[i];
            else if (ext_drv[i]) pin_in[i] = ext_val[i];
            else if (pullup_en[i] || i == 34) pin_in[i] = 1'b1; // resistor
            else pin_in[i] = wobble[i];
        end
    end
endmodule : gpiod_board
`default_nettype wire

// ==== testbench/gpiod_top_assertions.sv ====
// checker: bus and pad relations of the port block
`default_nettype none
module gpiod_top_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [gpiod_pkg::AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pslverr,
    input wire logic [31:0] prdata,
    input wire logic [39:0] pin_out,
    input wire logic [39:0] pin_oe,
    input wire logic [39:0] pullup_en
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic acc;
    logic od_reg;
    logic od_next;
    // =========== shadow of the write-only open-drain enable
    assign acc = psel && penable;
    always_comb od_next = (acc && pwrite && paddr == 12'h3a4) ? pwdata[2] : od_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) od_reg <= 1'b0;
        else od_reg <= od_next;
    end
    a_err_unmapped: assert property (acc && paddr[11:10] != 2'h0 |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_err_unaligned: assert property (acc && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("unaligned access not refused");
    a_upper_zero: assert property (acc |-> prdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    a_latch_load: assert property (acc && pwrite && paddr == 12'h344 |-> ##2
        pin_out[15:8] == $past(pwdata[7:0], 2)) else $error("latch not loaded");
    a_pullup_load: assert property (acc && pwrite && paddr == 12'h384 |-> ##2
        pullup_en[15:8] == $past(pwdata[7:0], 2)) else $error("pull-up not loaded");
    a_pullup_wo: assert property (acc && !pwrite && paddr == 12'h384 |-> prdata == 32'h0)
        else $error("write-only read not zero");
    a_dir_load: assert property (acc && pwrite && paddr == 12'h304 |-> ##2
        pin_oe[15:8] == $past(pwdata[7:0], 2)) else $error("direction not loaded");
    a_bit_set: assert property (acc && pwrite && paddr == 12'h3c4 |-> ##2
        pin_out[15:8] == ($past(pin_out[15:8], 2) | $past(pwdata[7:0], 2)))
        else $error("bit set disturbed latch");
    a_port0_upper: assert property ((pin_out[7:5] | pin_oe[7:5] | pullup_en[7:5]) == 3'h0)
        else $error("port zero upper bits active");
    // pads lag the control bit by one cycle, so check once it has settled
    a_od_no_high: assert property (od_reg && $past(od_reg) |-> !(pin_oe[34] && pin_out[34]))
        else $error("open-drain pin drove high");
    c_refused: cover property (acc && pslverr);
    c_od_low: cover property (od_reg && pin_oe[34]);
    c_bit_clear: cover property (acc && pwrite && paddr == 12'h3f4);
endmodule : gpiod_top_checker
bind gpiod_top gpiod_top_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr),
    .prdata(prdata), .pin_out(pin_out), .pin_oe(pin_oe), .pullup_en(pullup_en));
`default_nettype wire

// ==== testbench/gpiod_top_tb.sv ====
// testbench: register access, pad and open-drain checks of the port block
`default_nettype none
module gpiod_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [39:0] pin_in, pin_out, pin_oe, pullup_en, ext_drv, ext_val;
    logic [7:0] m, o;
    logic [7:0] dirs [5] = '{8'hb8, 8'hc1, 8'hc2, 8'hc4, 8'hc5};
    logic [7:0] offs [5] = '{8'h0, 8'h1, 8'h2, 8'h4, 8'h5};
    int fail_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    gpiod_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
        .prdata(prdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .pullup_en(pullup_en));
    gpiod_board u_board (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pullup_en(pullup_en), .ext_drv(ext_drv), .ext_val(ext_val), .pin_in(pin_in));
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    // =========== reporting
    task automatic end_sim;
        if (fail_count == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // a hung handshake ends the run as a failure
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fail_count++;
            end_sim();
        end
    end
    // =========== bus access: byte address is four times the register index
    function automatic logic [11:0] ra(input logic [7:0] idx);
        return {2'h0, idx, 2'h0};
    endfunction : ra
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // =========== main sequence
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        ext_val = 40'h5a_c3_96_3c_a5;
        ext_drv = 40'hfb_ff_ff_ff_ff; // open-drain pad left to its resistor
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        #1 chk(32'(|{pin_out, pin_oe, pullup_en}), 32'h0);
        for (int p = 0; p < 5; p++) begin
            m = (p == 0) ? 8'h1f : 8'hff;
            o = offs[p];
            apb(1'b0, ra(8'hd0 + o), 8'h0);
            // undriven pads sit on their resistor and read high
            chk(rd, {24'h0, (ext_val[p*8 +: 8] | ~ext_drv[p*8 +: 8]) & m});
            apb(1'b1, ra(8'hd0 + o), 8'ha5);
            apb(1'b1, ra(dirs[p]), 8'hff);
            @(posedge pclk);
            #1 chk({pin_oe[p*8 +: 8], pin_out[p*8 +: 8]}, {16'h0, m, 8'ha5 & m});
            apb(1'b0, ra(dirs[p]), 8'h0);
            chk(rd, {24'h0, m});
            apb(1'b0, ra(8'hd0 + o), 8'h0);
            chk(rd, {24'h0, 8'ha5 & m});
            apb(1'b1, ra(8'he0 + o), 8'h3c);
            @(posedge pclk);
            #1 chk({24'h0, pullup_en[p*8 +: 8]}, {24'h0, 8'h3c & m});
            apb(1'b0, ra(8'he0 + o), 8'h0);
            chk(rd, 32'h0);
            apb(1'b1, ra(8'hf0 + o), 8'h40);
            apb(1'b1, ra(8'hf8 + o), 8'h01);
            @(posedge pclk);
            #1 chk({24'h0, pin_out[p*8 +: 8]}, {24'h0, 8'he4 & m});
        end
        // port five bit two latch is already high and output before enabling
        apb(1'b1, ra(8'he9), 8'hff);
        @(posedge pclk);
        #1 chk({pin_oe[39:32], pin_out[39:32]}, 32'hfbe0);
        apb(1'b1, ra(8'hfd), 8'h04);
        @(posedge pclk);
        #1 chk({pin_oe[34], pin_out[34]}, 32'h2);
        apb(1'b0, ra(8'he9), 8'h0);
        chk(rd, 32'h0);
        apb(1'b1, ra(8'he9), 8'h00);
        apb(1'b1, ra(8'hf5), 8'h04);
        @(posedge pclk);
        #1 chk({pin_oe[39:32], pin_out[39:32]}, 32'hffe4);
        apb(1'b1, 12'h800, 8'hff);
        chk({rd[30:0], err}, 32'h1);
        apb(1'b1, 12'h341, 8'hff);
        @(posedge pclk);
        #1 chk({pin_out[7:0], 7'h0, err}, 32'h0401);
        end_sim();
    end
endmodule : gpiod_top_tb
`default_nettype wire
